/* rtl/ecc_top.sv */
// serial configuration, calibration sequencing and status pins of the encoder
`timescale 1ns/1ps
// What this block does
// - interpolation 0..1024, bits 10:8 in index_width_and_interp_high[2:0], bits 7:0 in interp_low_byte.
// - index width field 00=90, 01=180, 11=360 degrees; 10 invalid.
// - off-scale to on-scale transition starts autocalibration.
// - calibration trims index so its centre meets channel B centre.
// - calibration pin held high while on-scale starts autocalibration.
// - with calibration pin high, A+/B+/I+ report calibration progress.
// - calibration results take effect only after the next power cycle.
// - calibration indicator pulses 500 ms while running, high when done.
// - all indicators low at power-up; operating high only when ready.
// - fault indicator high when off-scale, pulsing on high current warning.
// - off-scale fault forces A+ B+ I- high, A- B- I+ low.
// - frame is write bit, 7-bit address, 8-bit data.
module ecc_top #(
   parameter int unsigned PULSE_CYC = ecc_pkg::PULSE_CYC
) (
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        NRST_I,
   // serial link
   input  wire logic        SCLK_I,
   input  wire logic        SPI_CS_N_I,
   input  wire logic        SDI_I,
   output logic             SDO_O,
   output logic             SDO_OE_O,
   // optical front end and calibration engine
   input  wire logic        OFFSCALE_I,
   input  wire logic        LED_WARN_I,
   input  wire logic        CAL_PIN_I,
   input  wire logic        INC_OK_I,
   input  wire logic        IDX_OK_I,
   input  wire logic        CAL_FAIL_I,
   input  wire logic [7:0]  IDX_OFS_I,
   output logic             CAL_RUN_O,
   // interpolator settings
   output logic [10:0]      INTERP_O,
   output logic [1:0]       IDX_WIDTH_O,
   output logic [7:0]       IDX_TRIM_O,
   // quadrature path
   input  wire logic        QA_I,
   input  wire logic        QB_I,
   input  wire logic        QI_I,
   output logic             A_P_O,
   output logic             A_N_O,
   output logic             B_P_O,
   output logic             B_N_O,
   output logic             I_P_O,
   output logic             I_N_O,
   // status indicators
   output logic             OPERATING_INDICATOR_O,
   output logic             CAL_STAT_O,
   output logic             ERR_STAT_O
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   logic       sclk_prev_q;
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         meta_q      <= 4'h2;
         sync_q      <= 4'h2;
         sclk_prev_q <= 1'b0;
      end else begin
         meta_q      <= {CAL_PIN_I, SDI_I, SPI_CS_N_I, SCLK_I};
         sync_q      <= meta_q;
         sclk_prev_q <= sync_q[0];
      end
   end
   logic sclk_rise;
   logic sclk_fall;
   logic cs_act;
   logic sdi_s;
   logic calpin_s;
   assign sclk_rise = sync_q[0] & ~sclk_prev_q;
   assign sclk_fall = ~sync_q[0] & sclk_prev_q;
   assign cs_act    = ~sync_q[1];
   assign sdi_s     = sync_q[2];
   assign calpin_s  = sync_q[3];

   // ---------------------------------------------------------------
   // serial engine, registers and nonvolatile sequencing
   // ---------------------------------------------------------------
   logic [4:0]  bit_cnt_q, bit_cnt_d;
   logic [14:0] shin_q, shin_d;
   logic [7:0]  shout_q, shout_d;
   logic        sdo_q, sdo_d;
   logic        unlock_q, unlock_d;
   logic [7:0]  page_q, page_d;
   logic [7:0]  cfg_hi_q, cfg_hi_d;
   logic [7:0]  cfg_lo_q, cfg_lo_d;
   logic [1:0]  wid_q, wid_d;
   logic [2:0]  boot_q, boot_d;
   logic [1:0]  prog_q, prog_d;
   logic [7:0]  trim_act_q, trim_act_d;
   logic [7:0]  trim_new_q, trim_new_d;
   logic        trim_pend_q, trim_pend_d;
   logic        booted;
   logic        wr_stb;
   logic        cfg_ok;
   logic        prog_go;
   logic [6:0]  wr_addr;
   logic [7:0]  wr_data;
   logic [6:0]  rd_addr;
   logic [7:0]  rd_data;
   logic        nvm_we;
   logic [1:0]  nvm_wa;
   logic [7:0]  nvm_wd;
   logic [1:0]  nvm_ra;
   logic [7:0]  nvm_rd;
   ecc_pkg::ecc_cal_t cal_q, cal_d;

   assign booted  = (boot_q == ecc_pkg::BOOT_DONE);
   assign wr_addr = shin_q[13:7];
   assign wr_data = {shin_q[6:0], sdi_s};
   assign rd_addr = {shin_q[5:0], sdi_s};
   assign wr_stb  = cs_act & sclk_rise & (bit_cnt_q == ecc_pkg::CNT_LAST) & shin_q[14];
   assign cfg_ok  = unlock_q & (page_q == ecc_pkg::PAGE_CFG);
   assign prog_go = wr_stb & cfg_ok & (wr_addr == ecc_pkg::ADDR_PROG)
                    & (wr_data == ecc_pkg::KEY_PROG);

   always_comb begin
      unique case (rd_addr)
         ecc_pkg::ADDR_CFG_HI: rd_data = cfg_hi_q;
         ecc_pkg::ADDR_CFG_LO: rd_data = cfg_lo_q;
         ecc_pkg::ADDR_PAGE:   rd_data = page_q;
         default:              rd_data = ecc_pkg::REG_RST;
      endcase
   end

   always_comb begin
      bit_cnt_d   = bit_cnt_q;
      shin_d      = shin_q;
      shout_d     = shout_q;
      sdo_d       = sdo_q;
      unlock_d    = unlock_q;
      page_d      = page_q;
      cfg_hi_d    = cfg_hi_q;
      cfg_lo_d    = cfg_lo_q;
      wid_d       = wid_q;
      boot_d      = boot_q;
      prog_d      = prog_q;
      trim_act_d  = trim_act_q;
      trim_pend_d = trim_pend_q;
      nvm_we      = 1'b0;
      nvm_wa      = ecc_pkg::NVM_TRIM;
      nvm_wd      = trim_new_q;
      nvm_ra      = boot_q[1:0];
      if (!cs_act) begin
         bit_cnt_d = '0;
         sdo_d     = 1'b0;
      end else if (sclk_rise) begin
         shin_d = {shin_q[13:0], sdi_s};
         if (bit_cnt_q != ecc_pkg::CNT_FULL) begin
            bit_cnt_d = bit_cnt_q + 5'h01;
         end
         if (bit_cnt_q == ecc_pkg::CNT_ADDR_DONE) begin
            shout_d = rd_data;
         end
      end else if (sclk_fall && bit_cnt_q >= ecc_pkg::CNT_DATA_FIRST
                   && bit_cnt_q != ecc_pkg::CNT_FULL) begin
         sdo_d   = shout_q[7];
         shout_d = {shout_q[6:0], 1'b0};
      end
      if (wr_stb) begin
         unique case (wr_addr)
            ecc_pkg::ADDR_UNLOCK: unlock_d = (wr_data == ecc_pkg::KEY_UNLOCK);
            ecc_pkg::ADDR_PAGE:   page_d = wr_data;
            ecc_pkg::ADDR_CFG_HI: begin
               if (cfg_ok) begin
                  cfg_hi_d = wr_data;
                  if (wr_data[ecc_pkg::IWID_LSB+:2] != ecc_pkg::WID_INVALID) begin
                     wid_d = wr_data[ecc_pkg::IWID_LSB+:2];
                  end
               end
            end
            ecc_pkg::ADDR_CFG_LO: begin
               if (cfg_ok) begin
                  cfg_lo_d = wr_data;
               end
            end
            default: ;
         endcase
      end
      if (prog_go) begin
         prog_d = 2'h1;
      end
      if (!booted) begin
         boot_d = boot_q + 3'h1;
         unique case (boot_q)
            3'h1: cfg_hi_d = nvm_rd;
            3'h2: cfg_lo_d = nvm_rd;
            3'h3: trim_act_d = nvm_rd;
            default: ;
         endcase
         if (boot_q == 3'h1 && nvm_rd[ecc_pkg::IWID_LSB+:2] != ecc_pkg::WID_INVALID) begin
            wid_d = nvm_rd[ecc_pkg::IWID_LSB+:2];
         end
      end else if (prog_q == 2'h1) begin
         nvm_we = 1'b1;
         nvm_wa = ecc_pkg::NVM_HI;
         nvm_wd = cfg_hi_q;
         prog_d = 2'h2;
      end else if (prog_q == 2'h2) begin
         nvm_we = 1'b1;
         nvm_wa = ecc_pkg::NVM_LO;
         nvm_wd = cfg_lo_q;
         prog_d = 2'h0;
      end else if (trim_pend_q) begin
         nvm_we      = 1'b1;
         trim_pend_d = 1'b0;
      end
      if (cal_q == ecc_pkg::CAL_INC && IDX_OK_I && !CAL_FAIL_I) begin
         trim_pend_d = 1'b1;
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         bit_cnt_q   <= '0;
         shin_q      <= '0;
         shout_q     <= ecc_pkg::REG_RST;
         sdo_q       <= 1'b0;
         unlock_q    <= 1'b0;
         page_q      <= ecc_pkg::REG_RST;
         cfg_hi_q    <= ecc_pkg::REG_RST;
         cfg_lo_q    <= ecc_pkg::REG_RST;
         wid_q       <= ecc_pkg::WID_90;
         boot_q      <= '0;
         prog_q      <= '0;
         trim_act_q  <= ecc_pkg::REG_RST;
         trim_pend_q <= 1'b0;
      end else begin
         bit_cnt_q   <= bit_cnt_d;
         shin_q      <= shin_d;
         shout_q     <= shout_d;
         sdo_q       <= sdo_d;
         unlock_q    <= unlock_d;
         page_q      <= page_d;
         cfg_hi_q    <= cfg_hi_d;
         cfg_lo_q    <= cfg_lo_d;
         wid_q       <= wid_d;
         boot_q      <= boot_d;
         prog_q      <= prog_d;
         trim_act_q  <= trim_act_d;
         trim_pend_q <= trim_pend_d;
      end
   end

   ecc_nvm #(.W(8), .D(4)) u_nvm (
      .clk_i   (CLK_I),
      .nrst_i  (NRST_I),
      .we_i    (nvm_we),
      .waddr_i (nvm_wa),
      .wdata_i (nvm_wd),
      .raddr_i (nvm_ra),
      .rdata_o (nvm_rd)
   );

   // ---------------------------------------------------------------
   // autocalibration sequencer
   // ---------------------------------------------------------------
   logic off_prev_q, off_prev_d;
   logic arm_prev_q, arm_prev_d;
   logic cal_trig;
   assign cal_trig = booted & ((off_prev_q & ~OFFSCALE_I)
                     | (calpin_s & ~OFFSCALE_I & ~arm_prev_q));

   always_comb begin
      cal_d      = cal_q;
      trim_new_d = trim_new_q;
      off_prev_d = OFFSCALE_I;
      arm_prev_d = calpin_s & ~OFFSCALE_I;
      unique case (cal_q)
         ecc_pkg::CAL_RUN: begin
            if (CAL_FAIL_I) begin
               cal_d = ecc_pkg::CAL_ERR;
            end else if (INC_OK_I) begin
               cal_d = ecc_pkg::CAL_INC;
            end
         end
         ecc_pkg::CAL_INC: begin
            if (CAL_FAIL_I) begin
               cal_d = ecc_pkg::CAL_ERR;
            end else if (IDX_OK_I) begin
               cal_d      = ecc_pkg::CAL_DONE;
               trim_new_d = trim_act_q - IDX_OFS_I;
            end
         end
         default: begin
            if (cal_trig) begin
               cal_d = ecc_pkg::CAL_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         cal_q      <= ecc_pkg::CAL_IDLE;
         trim_new_q <= ecc_pkg::REG_RST;
         off_prev_q <= 1'b0;
         arm_prev_q <= 1'b0;
      end else begin
         cal_q      <= cal_d;
         trim_new_q <= trim_new_d;
         off_prev_q <= off_prev_d;
         arm_prev_q <= arm_prev_d;
      end
   end

   // ---------------------------------------------------------------
   // pulse divider and registered pins
   // ---------------------------------------------------------------
   logic [ecc_pkg::DIV_W-1:0] div_q, div_d;
   logic blink_q, blink_d;
   logic [2:0] abi_q, abi_d;
   logic [2:0] stat_q, stat_d;
   logic cal_busy;
   logic fault;
   assign cal_busy = (cal_q == ecc_pkg::CAL_RUN) | (cal_q == ecc_pkg::CAL_INC);
   assign fault    = booted & OFFSCALE_I;

   always_comb begin
      div_d   = div_q + 1'b1;
      blink_d = blink_q;
      if (div_q == ecc_pkg::DIV_W'(PULSE_CYC - 1)) begin
         div_d   = '0;
         blink_d = ~blink_q;
      end
      abi_d = {QA_I, QB_I, QI_I};
      if (fault) begin
         abi_d = 3'h6;
      end else if (calpin_s) begin
         unique case (cal_q)
            ecc_pkg::CAL_RUN:  abi_d = 3'h0;
            ecc_pkg::CAL_INC:  abi_d = 3'h4;
            ecc_pkg::CAL_DONE: abi_d = 3'h2;
            ecc_pkg::CAL_ERR:  abi_d = 3'h6;
            default: ;
         endcase
      end
      stat_d[2] = booted & (cal_q == ecc_pkg::CAL_IDLE) & ~OFFSCALE_I & ~LED_WARN_I;
      stat_d[1] = (cal_busy & blink_q) | (cal_q == ecc_pkg::CAL_DONE);
      stat_d[0] = booted & (OFFSCALE_I | (LED_WARN_I & blink_q));
   end

   // every quadrature and status pin is a flop output or, for A-/B-/I-, its inverse, so no glitch reaches it
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         div_q   <= '0;
         blink_q <= 1'b0;
         abi_q   <= 3'h0;
         stat_q  <= 3'h0;
      end else begin
         div_q   <= div_d;
         blink_q <= blink_d;
         abi_q   <= abi_d;
         stat_q  <= stat_d;
      end
   end

   assign A_P_O       = abi_q[2];
   assign A_N_O       = ~abi_q[2];
   assign B_P_O       = abi_q[1];
   assign B_N_O       = ~abi_q[1];
   assign I_P_O       = abi_q[0];
   assign I_N_O       = ~abi_q[0];
   assign OPERATING_INDICATOR_O   = stat_q[2];
   assign CAL_STAT_O  = stat_q[1];
   assign ERR_STAT_O  = stat_q[0];
   assign SDO_O       = sdo_q;
   assign SDO_OE_O    = cs_act;
   assign CAL_RUN_O   = cal_busy;
   assign IDX_WIDTH_O = wid_q;
   assign IDX_TRIM_O  = trim_act_q;
   assign INTERP_O    = ({cfg_hi_q[ecc_pkg::INT_HI_MSB:0], cfg_lo_q} > ecc_pkg::INT_MAX)
                        ? ecc_pkg::INT_MAX : {cfg_hi_q[ecc_pkg::INT_HI_MSB:0], cfg_lo_q};

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);

   AST_CFG_STORE: assert property (wr_stb && cfg_ok && wr_addr == ecc_pkg::ADDR_CFG_LO
      |=> cfg_lo_q == $past(wr_data)) else $error("low byte not stored");
   AST_WIDTH_INVALID: assert property (wr_stb && wr_addr == ecc_pkg::ADDR_CFG_HI
      && wr_data[7:6] == ecc_pkg::WID_INVALID |=> $stable(IDX_WIDTH_O))
      else $error("invalid width taken");
   AST_PROG_NVM: assert property (booted && prog_q == 2'h0 && prog_go
      |=> nvm_we && nvm_wa == ecc_pkg::NVM_HI ##1 nvm_we && nvm_wa == ecc_pkg::NVM_LO)
      else $error("program did not store both bytes");
   AST_OFF_TRIG: assert property (booted && cal_q == ecc_pkg::CAL_IDLE
      && off_prev_q && !OFFSCALE_I |=> cal_q == ecc_pkg::CAL_RUN)
      else $error("off-scale exit did not start calibration");
   AST_TRIM: assert property (cal_q == ecc_pkg::CAL_INC && IDX_OK_I && !CAL_FAIL_I
      |=> trim_new_q == $past(trim_act_q) - $past(IDX_OFS_I) && trim_pend_q && nvm_we)
      else $error("index trim wrong");
   AST_PIN_STATUS: assert property (calpin_s && cal_q == ecc_pkg::CAL_INC && !OFFSCALE_I
      |=> A_P_O && !B_P_O && !I_P_O) else $error("progress code wrong");
   AST_TRIM_HELD: assert property (booted |=> $stable(IDX_TRIM_O))
      else $error("trim changed before power cycle");
   AST_CAL_DONE: assert property (cal_q == ecc_pkg::CAL_DONE [*2] |-> CAL_STAT_O && !OPERATING_INDICATOR_O)
      else $error("done indicator wrong");
   AST_OP_LOW: assert property (cal_q != ecc_pkg::CAL_IDLE |=> !OPERATING_INDICATOR_O)
      else $error("operating indicator high during calibration");
   AST_FAULT: assert property (fault |=> ERR_STAT_O && A_P_O && B_P_O && I_N_O)
      else $error("off-scale fault not shown");

   COV_DONE: cover property (cal_q == ecc_pkg::CAL_INC ##1 cal_q == ecc_pkg::CAL_DONE);
   COV_ERR: cover property (cal_q == ecc_pkg::CAL_RUN ##1 cal_q == ecc_pkg::CAL_ERR);
   COV_PROG: cover property (prog_go);
   COV_FAULT: cover property (fault ##1 !fault);
endmodule

/* inc/ecc_pkg.sv */
// constants and types shared by the encoder configuration and calibration block
package ecc_pkg;
   // ---------------------------------------------------------------
   // serial frame layout
   // ---------------------------------------------------------------
   localparam int unsigned FRAME_BITS = 16;
   localparam logic [4:0]  CNT_ADDR_DONE = 5'h07;
   localparam logic [4:0]  CNT_DATA_FIRST = 5'h08;
   localparam logic [4:0]  CNT_LAST = 5'h0F;
   localparam logic [4:0]  CNT_FULL = 5'h10;
   // ---------------------------------------------------------------
   // register map and keys
   // ---------------------------------------------------------------
   localparam logic [6:0]  ADDR_CFG_HI = 7'h0B;
   localparam logic [6:0]  ADDR_CFG_LO = 7'h0C;
   localparam logic [6:0]  ADDR_UNLOCK = 7'h10;
   localparam logic [6:0]  ADDR_PROG = 7'h11;
   localparam logic [6:0]  ADDR_PAGE = 7'h14;
   localparam logic [7:0]  KEY_UNLOCK = 8'hAB;
   localparam logic [7:0]  KEY_PROG = 8'hA1;
   localparam logic [7:0]  PAGE_CFG = 8'h00;
   localparam logic [7:0]  REG_RST = 8'h00;
   // ---------------------------------------------------------------
   // fields
   // ---------------------------------------------------------------
   localparam int unsigned IWID_LSB = 6;
   localparam int unsigned INT_HI_MSB = 2;
   localparam logic [10:0] INT_MAX = 11'h400;
   localparam logic [1:0]  WID_90 = 2'h0;
   localparam logic [1:0]  WID_INVALID = 2'h2;
   // ---------------------------------------------------------------
   // nonvolatile slots
   // ---------------------------------------------------------------
   localparam logic [1:0]  NVM_HI = 2'h0;
   localparam logic [1:0]  NVM_LO = 2'h1;
   localparam logic [1:0]  NVM_TRIM = 2'h2;
   localparam logic [2:0]  BOOT_DONE = 3'h4;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned PULSE_MS = 500;
   localparam int unsigned PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
   localparam int unsigned DIV_W = 27;
   // ---------------------------------------------------------------
   // calibration states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {CAL_IDLE, CAL_RUN, CAL_INC, CAL_DONE, CAL_ERR} ecc_cal_t;
endpackage

/* rtl/ecc_nvm.sv */
// nonvolatile configuration store, kept across resets
`timescale 1ns/1ps
module ecc_nvm #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 4
) (
   // clock and reset of the read register
   input  wire logic                 clk_i,
   input  wire logic                 nrst_i,
   // write port
   input  wire logic                 we_i,
   input  wire logic [$clog2(D)-1:0] waddr_i,
   input  wire logic [W-1:0]         wdata_i,
   // read port
   input  wire logic [$clog2(D)-1:0] raddr_i,
   output logic      [W-1:0]         rdata_o
);
   // factory contents are all zero
   logic [W-1:0] mem_q [D] = '{default: '0};

   // array holds no reset so it outlives a power cycle
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem_q[raddr_i];
      end
   end
endmodule

/* dv/ecc_host.sv */
// host model driving the serial configuration link
`timescale 1ns/1ps
module ecc_host (
   // serial link
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      sdi_o,
   input  wire logic sdo_i
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o  = 1'b0;
   end
   // ---------------------------------------------------------------
   // one frame, msb first; read data sampled on rises 9 to 16
   // ---------------------------------------------------------------
   task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
      cs_n_o = 1'b0;
      #40;
      for (int i = 15; i >= 0; i--) begin
         sdi_o = w[i];
         #40 sclk_o = 1'b1;
         if (i < 8) rd[i] = sdo_i;
         #40 sclk_o = 1'b0;
      end
      #40 cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #80;
   endtask
endmodule

/* dv/testbench.sv */
// self-checking bench of the encoder configuration and calibration block
`timescale 1ns/1ps
module testbench;
   logic       clk = 1'b0, nrst = 1'b0, offs = 1'b0, warn = 1'b0, calp = 1'b0;
   logic       inc = 1'b0, idx = 1'b0, fail = 1'b0, qa = 1'b0, qb = 1'b0, qi = 1'b0;
   logic       sclk, cs_n, sdi, sdo, oe, run, ap, an, bp, bn, ip, in_n, op, cst, er;
   logic [7:0] ofs = 8'h10, trim, rd;
   logic [10:0] interp;
   logic [1:0] wid;
   int         err_total = 0;
   int         n_compared = 0;

   always #2 clk = ~clk;

   ecc_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
   ecc_top #(.PULSE_CYC(8)) i_dut (
      .CLK_I(clk), .NRST_I(nrst), .SCLK_I(sclk), .SPI_CS_N_I(cs_n), .SDI_I(sdi),
      .SDO_O(sdo), .SDO_OE_O(oe), .OFFSCALE_I(offs), .LED_WARN_I(warn),
      .CAL_PIN_I(calp), .INC_OK_I(inc), .IDX_OK_I(idx), .CAL_FAIL_I(fail),
      .IDX_OFS_I(ofs), .CAL_RUN_O(run), .INTERP_O(interp), .IDX_WIDTH_O(wid),
      .IDX_TRIM_O(trim), .QA_I(qa), .QB_I(qb), .QI_I(qi), .A_P_O(ap), .A_N_O(an),
      .B_P_O(bp), .B_N_O(bn), .I_P_O(ip), .I_N_O(in_n), .OPERATING_INDICATOR_O(op),
      .CAL_STAT_O(cst), .ERR_STAT_O(er));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic results;
      if (err_total == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic rst;
      nrst = 1'b0;
      tick(3);
      nrst = 1'b1;
      tick(10);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_host.xfer({1'b1, a, d}, rd);
   endtask
   task automatic rdb(input logic [6:0] a);
      i_host.xfer({1'b0, a, 8'h00}, rd);
   endtask
   task automatic tog(input bit w, output int n);
      logic p;
      n = 0;
      p = w ? er : cst;
      repeat (40) begin
         tick(1);
         if ((w ? er : cst) !== p) n++;
         p = w ? er : cst;
      end
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_ready;
      chk("op_ready", 1, op);
      fork
         wr(7'h7F, 8'h00);
         begin
            tick(20);
            chk("sdo_oe_frame", 1, oe);
         end
      join
      chk("sdo_oe_idle", 0, oe);
      qa = 1'b1;
      tick(3);
      chk("a_pair", 2'b10, {ap, an});
      qa = 1'b0;
   endtask
   task automatic t_regs;
      logic [1:0] ws[3] = '{2'h0, 2'h1, 2'h3};
      wr(7'h0B, 8'h05);
      rdb(7'h0B);
      chk("locked_rd", 8'h00, rd);
      wr(7'h10, 8'hAB);
      wr(7'h14, 8'h00);
      foreach (ws[k]) begin
         wr(7'h0B, {ws[k], 6'h02});
         wr(7'h0C, 8'h34);
         chk("interp", 11'h234, interp);
         chk("width", ws[k], wid);
         rdb(7'h0B);
         chk("rd_hi", {ws[k], 6'h02}, rd);
      end
      wr(7'h0B, 8'h84);
      chk("width_bad", 2'h3, wid);
      rdb(7'h0C);
      chk("rd_lo", 8'h34, rd);
      wr(7'h0B, 8'h07);
      wr(7'h0C, 8'hFF);
      chk("interp_sat", 11'h400, interp);
      wr(7'h0B, 8'h44);
      wr(7'h0C, 8'h00);
      rdb(7'h10);
      chk("rd_key", 8'h00, rd);
      wr(7'h11, 8'hA1);
      rst;
      chk("kept_int", 11'h400, interp);
      chk("kept_wid", 2'h1, wid);
   endtask
   task automatic t_offcal;
      int n;
      offs = 1'b1;
      tick(3);
      chk("fault_pins", 6'b101001, {ap, an, bp, bn, ip, in_n});
      chk("fault_stat", 2'b01, {op, er});
      offs = 1'b0;
      tick(2);
      chk("run", 1, run);
      chk("op_cal", 0, op);
      calp = 1'b1;
      tick(4);
      chk("code_run", 3'b000, {ap, bp, ip});
      tog(1'b0, n);
      chk("cal_blink", 1, n >= 4 && n <= 6);
      inc = 1'b1;
      tick(1);
      inc = 1'b0;
      tick(3);
      chk("code_inc", 3'b100, {ap, bp, ip});
      idx = 1'b1;
      tick(1);
      idx = 1'b0;
      tick(3);
      chk("code_done", 3'b010, {ap, bp, ip});
      chk("cal_done", 2'b10, {cst, run});
      chk("trim_old", 8'h00, trim);
      calp = 1'b0;
      rst;
      chk("trim_new", 8'hF0, trim);
   endtask
   task automatic t_pincal;
      int n;
      calp = 1'b1;
      tick(5);
      chk("pin_run", 1, run);
      fail = 1'b1;
      tick(1);
      fail = 1'b0;
      tick(3);
      chk("code_err", 3'b110, {ap, bp, ip});
      chk("err_stat", 2'b00, {cst, op});
      calp = 1'b0;
      rst;
      warn = 1'b1;
      tog(1'b1, n);
      chk("warn_blink", 1, n >= 4 && n <= 6);
      chk("op_warn", 0, op);
      warn = 1'b0;
   endtask

   initial begin
      rst;
      t_ready;
      t_regs;
      t_offcal;
      t_pincal;
      results;
   end
   initial begin
      #200000;
      err_total++;
      results;
   end
endmodule
